/* rtl/asp_consts.svh */
// Register offsets, field positions and timing constants of the serial port
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

`define ASP_ADDR_CCR       16'h7050
`define ASP_ADDR_CTL1      16'h7051
`define ASP_ADDR_HBAUD     16'h7052
`define ASP_ADDR_LBAUD     16'h7053
`define ASP_ADDR_CTL2      16'h7054
`define ASP_ADDR_RXST      16'h7055
`define ASP_ADDR_RXEMU     16'h7056
`define ASP_ADDR_RXBUF     16'h7057
`define ASP_ADDR_TXBUF     16'h7059
`define ASP_ADDR_FFTX      16'h705A
`define ASP_ADDR_FFRX      16'h705B
`define ASP_ADDR_FFCT      16'h705C
`define ASP_ADDR_PRI       16'h705F

`define ASP_CCR_STOP2      7
`define ASP_CCR_EVEN       6
`define ASP_CCR_PAREN      5
`define ASP_CCR_ADDRMODE   3
`define ASP_CCR_LEN_MSB    2

`define ASP_CTL1_RXENA     0
`define ASP_CTL1_TXENA     1
`define ASP_CTL1_TXWAKE    3
`define ASP_CTL1_SWRST     5
`define ASP_CTL1_RXERRIE   6

`define ASP_IE_TX          0
`define ASP_IE_RXBK        1

`define ASP_FFTX_EN        14
`define ASP_FFRX_OVF       15
`define ASP_FFRX_OVFCLR    14
`define ASP_FFCT_ABD       15
`define ASP_FFCT_ABDCLR    14
`define ASP_FFCT_CDC       13

`define ASP_DIV_ZERO_PERIOD 20'h00010
`define ASP_DIV_SHIFT       3
`define ASP_IDLE_BITS       4'hA
`define ASP_AB_MIN          20'h00010
`define ASP_FIFO_DEPTH      4
`define ASP_FIFO_LIMIT      3'h4
`define ASP_HOLD_LIMIT      3'h1

`endif

/* rtl/asp_pkg.sv */
// Types shared by the serial port modules
package asp_pkg;

  typedef enum logic {ASP_TX_IDLE, ASP_TX_SHIFT} asp_tx_e;
  typedef enum logic [1:0] {ASP_RX_IDLE, ASP_RX_START, ASP_RX_BITS} asp_rx_e;

  typedef struct packed {
    asp_tx_e     st;
    logic [12:0] shift;
    logic [3:0]  cnt;
    logic [19:0] tim;
  } asp_tx_s;

  typedef struct packed {
    asp_rx_e     st;
    logic [10:0] bits;
    logic [3:0]  idx;
    logic [19:0] tim;
    logic [3:0]  idle;
    logic        wake_pend;
  } asp_rx_s;

  typedef struct packed {
    logic [7:0]  ccr;
    logic [7:0]  ctl1;
    logic [15:0] baud;
    logic [1:0]  ie;
    logic [7:0]  pri;
    logic        fifo_en;
    logic        ovf;
    logic        abd;
    logic        cdc;
    logic        pe;
    logic        oe;
    logic        fe;
    logic        brk;
    logic        wake;
    logic        ab_meas;
    logic [19:0] ab_cnt;
    logic [15:0] rdata;
  } asp_cfg_s;

endpackage

/* rtl/asp_stream_if.sv */
// Valid/ready byte stream between the port logic and its queues
`timescale 1ns/1ps
`default_nettype none
interface asp_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/asp_queue.sv */
// Byte queue with a programmable fill limit
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
module asp_queue
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        flush,
  input  wire logic [2:0]  limit,
  output logic      [2:0]  level,
  asp_stream_if.snk        wr,
  asp_stream_if.src        rd
);
  logic [7:0] mem_reg  [0:`ASP_FIFO_DEPTH-1];
  logic [7:0] mem_next [0:`ASP_FIFO_DEPTH-1];
  logic [1:0] wp_reg;
  logic [1:0] wp_next;
  logic [1:0] rp_reg;
  logic [1:0] rp_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       push;
  logic       pop;

  assign wr.ready = (cnt_reg < limit) && !flush;
  assign rd.valid = (cnt_reg != 3'h0) && !flush;
  assign rd.data  = mem_reg[rp_reg];
  assign level    = cnt_reg;
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb
  begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg + {2'h0, push} - {2'h0, pop};
    if (push)
    begin
      mem_next[wp_reg] = wr.data;
      wp_next          = wp_reg + 2'h1;
    end
    if (pop)
      rp_next = rp_reg + 2'h1;
    if (flush)
    begin
      wp_next  = 2'h0;
      rp_next  = 2'h0;
      cnt_next = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `ASP_FIFO_DEPTH; i++)
        mem_reg[i] <= 8'h00;
      wp_reg  <= 2'h0;
      rp_reg  <= 2'h0;
      cnt_reg <= 3'h0;
    end
    else
    begin
      mem_reg <= mem_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* rtl/asp_serial_port.sv */
// Asynchronous serial port: registers, baud timing, transmitter, receiver
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
// Notes on behaviour
// - Bit time is divisor plus one times eight clocks, sixteen if divisor zero.
// - Frame: start, one to eight data, optional parity, one or two stops.
// - Receiver flags break, parity, overrun and framing errors separately.
// - Wake-up by idle-line gap or by extra address bit.
// - Both directions buffered ahead of shifter, own enable and interrupt enable.
// - Transmitter and receiver run independently, full duplex possible.
// - Holding-free flag when buffer accepts; empty flag when shifter idle and buffer empty.
// - Receive ready, break seen, and error flag ORing four errors.
// - Separate interrupt enables; break shares the receive enable.
// - Control registers except the three FIFO ones use low byte; upper byte reads zero, ignores writes.
// - Hardware measures incoming bit time and loads the divisor.
// - Optional four-entry transmit and receive queues.
// - NRZ link: dedicated output pin and dedicated input pin.
module asp_serial_port
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] addr,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             tx_irq,
  output logic             rx_irq
);
  asp_pkg::asp_tx_s  tx_reg;
  asp_pkg::asp_tx_s  tx_next;
  asp_pkg::asp_rx_s  rx_reg;
  asp_pkg::asp_rx_s  rx_next;
  asp_pkg::asp_cfg_s cfg_reg;
  asp_pkg::asp_cfg_s cfg_next;
  logic              sync1_reg;
  logic              sync2_reg;
  logic              rx_line;
  logic              sw_run;
  logic              tx_take;
  logic              tx_holding_free;
  logic              tx_empty;
  logic              rx_char_available;
  logic              break_seen;
  logic              rx_error;
  logic              rx_done;
  logic              ev_pe;
  logic              ev_fe;
  logic              ev_brk;
  logic              ev_oe;
  logic              ev_wake;
  logic [2:0]        q_limit;
  logic [2:0]        txq_level;
  logic [2:0]        rxq_level;
  logic [19:0]       period;

  asp_stream_if txq_wr ();
  asp_stream_if txq_rd ();
  asp_stream_if rxq_wr ();
  asp_stream_if rxq_rd ();

  // ****************************************************
  // Helper functions
  // ****************************************************
  function automatic logic [19:0] bit_period(input logic [15:0] d);
    if (d == 16'h0000)
      bit_period = `ASP_DIV_ZERO_PERIOD;
    else
      bit_period = ({4'h0, d} + 20'h00001) << `ASP_DIV_SHIFT;
  endfunction

  function automatic logic [7:0] len_mask(input logic [7:0] ccr);
    len_mask = 8'hFF >> (3'h7 - ccr[`ASP_CCR_LEN_MSB:0]);
  endfunction

  function automatic logic [3:0] data_len(input logic [7:0] ccr);
    data_len = {1'b0, ccr[`ASP_CCR_LEN_MSB:0]} + 4'h1;
  endfunction

  function automatic logic [3:0] payload_bits(input logic [7:0] ccr);
    payload_bits = data_len(ccr) + {3'h0, ccr[`ASP_CCR_ADDRMODE]}
                 + {3'h0, ccr[`ASP_CCR_PAREN]};
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic a,
                                   input logic [7:0] ccr);
    par_bit = ^{d, a & ccr[`ASP_CCR_ADDRMODE]} ^ ~ccr[`ASP_CCR_EVEN];
  endfunction

  // ****************************************************
  // Input synchroniser and queues
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= serial_in_pin;
      sync2_reg <= sync1_reg;
    end
  end
  assign rx_line = sync2_reg;
  assign sw_run  = cfg_reg.ctl1[`ASP_CTL1_SWRST];
  assign period  = bit_period(cfg_reg.baud);

  assign q_limit = cfg_reg.fifo_en ? `ASP_FIFO_LIMIT : `ASP_HOLD_LIMIT;

  asp_queue u_txq
  (
    .clk     (clk),
    .reset_n (reset_n),
    .flush   (!sw_run),
    .limit   (q_limit),
    .level   (txq_level),
    .wr      (txq_wr),
    .rd      (txq_rd)
  );
  asp_queue u_rxq
  (
    .clk     (clk),
    .reset_n (reset_n),
    .flush   (!sw_run),
    .limit   (q_limit),
    .level   (rxq_level),
    .wr      (rxq_wr),
    .rd      (rxq_rd)
  );

  assign txq_wr.valid = wr_en && (addr == `ASP_ADDR_TXBUF);
  assign txq_wr.data  = wdata[7:0];
  assign txq_rd.ready = tx_take;
  assign rxq_rd.ready = rd_en && (addr == `ASP_ADDR_RXBUF);

  // ****************************************************
  // Transmitter
  // ****************************************************
  always_comb
  begin
    logic [11:0] v;
    logic [3:0]  l;
    v       = '1;
    l       = data_len(cfg_reg.ccr);
    tx_next = tx_reg;
    tx_take = 1'b0;
    case (tx_reg.st)
      asp_pkg::ASP_TX_IDLE:
      begin
        tx_next.shift = '1;
        if (txq_rd.valid && sw_run && cfg_reg.ctl1[`ASP_CTL1_TXENA])
        begin
          tx_take = 1'b1;
          v = {4'hF, txq_rd.data & len_mask(cfg_reg.ccr)}
            | {4'h0, ~len_mask(cfg_reg.ccr)};
          if (cfg_reg.ccr[`ASP_CCR_ADDRMODE])
            v[l] = cfg_reg.ctl1[`ASP_CTL1_TXWAKE];
          if (cfg_reg.ccr[`ASP_CCR_PAREN])
            v[l + {3'h0, cfg_reg.ccr[`ASP_CCR_ADDRMODE]}] =
              par_bit(txq_rd.data & len_mask(cfg_reg.ccr),
                      cfg_reg.ctl1[`ASP_CTL1_TXWAKE], cfg_reg.ccr);
          tx_next.shift = {v, 1'b0};
          tx_next.cnt   = payload_bits(cfg_reg.ccr) + 4'h2
                        + {3'h0, cfg_reg.ccr[`ASP_CCR_STOP2]};
          tx_next.tim   = period - 20'h00001;
          tx_next.st    = asp_pkg::ASP_TX_SHIFT;
        end
      end
      asp_pkg::ASP_TX_SHIFT:
      begin
        if (tx_reg.tim != 20'h00000)
          tx_next.tim = tx_reg.tim - 20'h00001;
        else if (tx_reg.cnt == 4'h1)
        begin
          tx_next.st    = asp_pkg::ASP_TX_IDLE;
          tx_next.shift = '1;
        end
        else
        begin
          tx_next.shift = {1'b1, tx_reg.shift[12:1]};
          tx_next.cnt   = tx_reg.cnt - 4'h1;
          tx_next.tim   = period - 20'h00001;
        end
      end
      default:
      begin
        tx_next.st    = asp_pkg::ASP_TX_IDLE;
        tx_next.shift = '1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_reg <= '{st: asp_pkg::ASP_TX_IDLE, shift: '1, cnt: '0, tim: '0};
    else
      tx_reg <= tx_next;
  end

  assign serial_out_pin  = tx_reg.shift[0];
  assign tx_holding_free = txq_wr.ready;
  assign tx_empty        = (tx_reg.st == asp_pkg::ASP_TX_IDLE)
                        && (txq_level == 3'h0);

  // ****************************************************
  // Receiver
  // ****************************************************
  always_comb
  begin
    logic [3:0] l;
    logic       a;
    logic [7:0] d;
    l       = data_len(cfg_reg.ccr);
    a       = 1'b0;
    d       = 8'h00;
    rx_next = rx_reg;
    rx_done = 1'b0;
    case (rx_reg.st)
      asp_pkg::ASP_RX_IDLE:
      begin
        if (!rx_line)
        begin
          rx_next.st        = asp_pkg::ASP_RX_START;
          rx_next.tim       = period >> 1;
          rx_next.wake_pend = rx_reg.idle >= `ASP_IDLE_BITS;
          rx_next.bits      = '0;
          rx_next.idx       = 4'h0;
        end
        else if (rx_reg.tim == 20'h00000)
        begin
          rx_next.tim = period - 20'h00001;
          if (rx_reg.idle != `ASP_IDLE_BITS)
            rx_next.idle = rx_reg.idle + 4'h1;
        end
        else
          rx_next.tim = rx_reg.tim - 20'h00001;
      end
      asp_pkg::ASP_RX_START:
      begin
        if (rx_reg.tim != 20'h00000)
          rx_next.tim = rx_reg.tim - 20'h00001;
        else if (rx_line)
          rx_next.st = asp_pkg::ASP_RX_IDLE;
        else
        begin
          rx_next.st  = asp_pkg::ASP_RX_BITS;
          rx_next.tim = period - 20'h00001;
        end
      end
      asp_pkg::ASP_RX_BITS:
      begin
        if (rx_reg.tim != 20'h00000)
          rx_next.tim = rx_reg.tim - 20'h00001;
        else
        begin
          rx_next.bits[rx_reg.idx] = rx_line;
          rx_next.tim              = period - 20'h00001;
          if (rx_reg.idx == payload_bits(cfg_reg.ccr))
          begin
            rx_done      = 1'b1;
            rx_next.st   = asp_pkg::ASP_RX_IDLE;
            rx_next.idle = 4'h0;
          end
          else
            rx_next.idx = rx_reg.idx + 4'h1;
        end
      end
      default:
        rx_next.st = asp_pkg::ASP_RX_IDLE;
    endcase
    if (!sw_run || !cfg_reg.ctl1[`ASP_CTL1_RXENA])
    begin
      rx_next.st = asp_pkg::ASP_RX_IDLE;
      rx_done    = 1'b0;
    end
    d = rx_next.bits[7:0] & len_mask(cfg_reg.ccr);
    a = cfg_reg.ccr[`ASP_CCR_ADDRMODE] && rx_next.bits[l];
    ev_pe  = rx_done && cfg_reg.ccr[`ASP_CCR_PAREN]
          && (rx_next.bits[l + {3'h0, cfg_reg.ccr[`ASP_CCR_ADDRMODE]}]
              != par_bit(d, a, cfg_reg.ccr));
    ev_fe  = rx_done && !rx_next.bits[payload_bits(cfg_reg.ccr)];
    ev_brk = ev_fe && (rx_next.bits == 11'h000);
    ev_oe  = rx_done && !rxq_wr.ready;
    ev_wake = rx_done && (cfg_reg.ccr[`ASP_CCR_ADDRMODE] ? a
                                                         : rx_reg.wake_pend);
    rxq_wr.valid = rx_done;
    rxq_wr.data  = d;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_reg <= '{st: asp_pkg::ASP_RX_IDLE, default: '0};
    else
      rx_reg <= rx_next;
  end

  // ****************************************************
  // Registers, flags and rate detection
  // ****************************************************
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_en)
    begin
      case (addr)
        `ASP_ADDR_CCR:   cfg_next.ccr = wdata[7:0];
        `ASP_ADDR_CTL1:  cfg_next.ctl1 = wdata[7:0];
        `ASP_ADDR_HBAUD: cfg_next.baud[15:8] = wdata[7:0];
        `ASP_ADDR_LBAUD: cfg_next.baud[7:0] = wdata[7:0];
        `ASP_ADDR_CTL2:  cfg_next.ie = wdata[`ASP_IE_RXBK:`ASP_IE_TX];
        `ASP_ADDR_PRI:   cfg_next.pri = wdata[7:0];
        `ASP_ADDR_FFTX:  cfg_next.fifo_en = wdata[`ASP_FFTX_EN];
        `ASP_ADDR_FFRX:
          if (wdata[`ASP_FFRX_OVFCLR])
            cfg_next.ovf = 1'b0;
        `ASP_ADDR_FFCT:
        begin
          cfg_next.cdc = wdata[`ASP_FFCT_CDC];
          if (wdata[`ASP_FFCT_ABDCLR])
            cfg_next.abd = 1'b0;
        end
        default:
          cfg_next.pri = cfg_reg.pri;
      endcase
    end
    if (rd_en && (addr == `ASP_ADDR_RXBUF))
    begin
      cfg_next.pe = 1'b0;
      cfg_next.fe = 1'b0;
    end
    if (!sw_run)
    begin
      cfg_next.pe   = 1'b0;
      cfg_next.oe   = 1'b0;
      cfg_next.fe   = 1'b0;
      cfg_next.brk  = 1'b0;
      cfg_next.wake = 1'b0;
      cfg_next.ovf  = 1'b0;
    end
    cfg_next.pe   = cfg_next.pe   | ev_pe;
    cfg_next.oe   = cfg_next.oe   | ev_oe;
    cfg_next.fe   = cfg_next.fe   | ev_fe;
    cfg_next.brk  = cfg_next.brk  | ev_brk;
    cfg_next.ovf  = cfg_next.ovf  | (ev_oe && cfg_reg.fifo_en);
    if (rx_done)
      cfg_next.wake = ev_wake;
    if (cfg_reg.cdc && !cfg_reg.abd)
    begin
      if (!cfg_reg.ab_meas && !rx_line)
      begin
        cfg_next.ab_meas = 1'b1;
        cfg_next.ab_cnt  = 20'h00001;
      end
      else if (cfg_reg.ab_meas && rx_line)
      begin
        cfg_next.ab_meas = 1'b0;
        if (cfg_reg.ab_cnt >= `ASP_AB_MIN)
        begin
          cfg_next.baud = cfg_reg.ab_cnt[18:3] - 16'h0001;
          cfg_next.abd  = 1'b1;
        end
      end
      else if (cfg_reg.ab_meas && (cfg_reg.ab_cnt != '1))
        cfg_next.ab_cnt = cfg_reg.ab_cnt + 20'h00001;
    end
    else
      cfg_next.ab_meas = 1'b0;
    if (rd_en)
    begin
      case (addr)
        `ASP_ADDR_CCR:   cfg_next.rdata = {8'h00, cfg_reg.ccr};
        `ASP_ADDR_CTL1:  cfg_next.rdata = {8'h00, cfg_reg.ctl1};
        `ASP_ADDR_HBAUD: cfg_next.rdata = {8'h00, cfg_reg.baud[15:8]};
        `ASP_ADDR_LBAUD: cfg_next.rdata = {8'h00, cfg_reg.baud[7:0]};
        `ASP_ADDR_CTL2:
          cfg_next.rdata = {8'h00, tx_holding_free, tx_empty, 4'h0,
                            cfg_reg.ie};
        `ASP_ADDR_RXST:
          cfg_next.rdata = {8'h00, rx_error, rx_char_available, cfg_reg.brk,
                            cfg_reg.fe, cfg_reg.oe, cfg_reg.pe, cfg_reg.wake,
                            1'b0};
        `ASP_ADDR_RXEMU: cfg_next.rdata = {8'h00, rxq_rd.data};
        `ASP_ADDR_RXBUF: cfg_next.rdata = {8'h00, rxq_rd.data};
        `ASP_ADDR_FFTX:
          cfg_next.rdata = {1'b0, cfg_reg.fifo_en, 3'h0, txq_level, 8'h00};
        `ASP_ADDR_FFRX:
          cfg_next.rdata = {cfg_reg.ovf, 4'h0, rxq_level, 8'h00};
        `ASP_ADDR_FFCT:
          cfg_next.rdata = {cfg_reg.abd, 1'b0, cfg_reg.cdc, 13'h0000};
        `ASP_ADDR_PRI:   cfg_next.rdata = {8'h00, cfg_reg.pri};
        default:         cfg_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_reg <= '0;
    else
      cfg_reg <= cfg_next;
  end

  assign rdata             = cfg_reg.rdata;
  assign rx_char_available = rxq_rd.valid;
  assign break_seen        = cfg_reg.brk;
  assign rx_error = cfg_reg.pe | cfg_reg.oe | cfg_reg.fe | cfg_reg.brk;
  assign tx_irq = cfg_reg.ie[`ASP_IE_TX] && tx_holding_free;
  assign rx_irq = (cfg_reg.ie[`ASP_IE_RXBK]
                   && (rx_char_available || break_seen))
               || (cfg_reg.ctl1[`ASP_CTL1_RXERRIE] && rx_error);

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  line_idle_high_a: assert property (
    (tx_reg.st == asp_pkg::ASP_TX_IDLE) |-> serial_out_pin)
    else $error("output low while transmitter idle");
  start_bit_low_a: assert property (
    tx_take |=> !serial_out_pin [*2])
    else $error("start bit missing");
  bit_hold_a: assert property (
    (tx_reg.st == asp_pkg::ASP_TX_SHIFT && tx_reg.tim != 20'h00000)
    |=> $stable(serial_out_pin))
    else $error("output changed inside a bit time");
  div_zero_a: assert property (
    (tx_take && cfg_reg.baud == 16'h0000 && !wr_en)
    |=> tx_reg.tim == `ASP_DIV_ZERO_PERIOD - 20'h00001)
    else $error("zero divisor bit time wrong");
  stop_high_a: assert property (
    (tx_reg.st == asp_pkg::ASP_TX_SHIFT && tx_reg.cnt == 4'h1)
    |-> serial_out_pin)
    else $error("stop bit not high");
  overrun_flag_a: assert property (
    (ev_oe && sw_run) |=> cfg_reg.oe && rx_error)
    else $error("overrun not flagged");
  break_flag_a: assert property (
    (ev_brk && sw_run) |=> break_seen && cfg_reg.fe)
    else $error("break not flagged");
  tx_flags_a: assert property (
    (tx_empty && sw_run) |-> tx_holding_free)
    else $error("empty transmitter not ready");
  upper_zero_a: assert property (
    (rd_en && addr == `ASP_ADDR_CCR) |=> rdata[15:8] == 8'h00)
    else $error("upper byte not zero");
  rx_off_idle_a: assert property (
    !cfg_reg.ctl1[`ASP_CTL1_RXENA] |=> rx_reg.st == asp_pkg::ASP_RX_IDLE)
    else $error("receiver active while disabled");
  autobaud_load_a: assert property (
    $rose(cfg_reg.abd) |-> cfg_reg.baud == $past(cfg_reg.ab_cnt[18:3])
                                          - 16'h0001)
    else $error("detected rate not loaded");
  rx_buffered_a: assert property (
    (rxq_wr.valid && rxq_wr.ready) |=> rx_char_available)
    else $error("received character not buffered");
endmodule
`default_nettype wire

/* verification/asp_peer.sv */
// Far serial node model: sends, receives and breaks NRZ characters
`timescale 1ns/1ps
`default_nettype none
module asp_peer
(
  input  wire logic clk,
  input  wire logic rx_line,
  output logic      tx_line
);
  int bt = 16;
  initial tx_line = 1'b1;
  // start, eight bits LSB first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      tx_line <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask
  task automatic brk();
    @(posedge clk);
    tx_line <= 1'b0;
    repeat (12 * bt) @(posedge clk);
    tx_line <= 1'b1;
  endtask
  // mid-bit sampling, stop must be high
  task automatic get(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (rx_line !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bt) @(posedge clk);
      b[i] = rx_line;
    end
    repeat (bt) @(posedge clk);
    ok = (n < 4000) && (rx_line === 1'b1);
  endtask
endmodule
`default_nettype wire

/* verification/test_async_serial_port.sv */
// Self-checking bench of the serial port against the far node model
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
module test_async_serial_port;
  logic        clk;
  logic        reset_n;
  logic [15:0] addr;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rx_line;
  logic        tx_line;
  logic        tx_irq;
  logic        rx_irq;
  int          bad_count;
  int          num_checks;
  int          seed;
  logic [15:0] v;
  logic [7:0]  tb_b;
  logic [7:0]  r;
  logic [7:0]  g;
  logic        ok;
  logic [7:0]  q [0:4];

  asp_serial_port DUT
  (
    .clk            (clk),
    .reset_n        (reset_n),
    .addr           (addr),
    .wr_en          (wr_en),
    .rd_en          (rd_en),
    .wdata          (wdata),
    .rdata          (rdata),
    .serial_in_pin  (rx_line),
    .serial_out_pin (tx_line),
    .tx_irq         (tx_irq),
    .rx_irq         (rx_irq)
  );
  asp_peer peer
  (
    .clk     (clk),
    .rx_line (tx_line),
    .tx_line (rx_line)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************
  // Bench helpers
  // ****************
  function automatic int bt_of(input int d);
    return (d == 0) ? 16 : (d + 1) * 8;
  endfunction
  // Frame setting per mode: plain eight bits, even parity, address bit
  function automatic logic [15:0] ccr_of(input int m);
    return (m == 0) ? 16'h0007 : (m == 1) ? 16'h0066 : 16'h000E;
  endfunction
  // Byte seen on the link; parity or a cleared address bit takes bit 7
  function automatic logic [7:0] on_wire(input logic [7:0] b, input int m);
    return (m == 0) ? b : {(m == 1) && (^b[6:0]), b[6:0]};
  endfunction
  // Expected parity error and wake status bits for a received byte
  function automatic logic [15:0] st_of(input logic [7:0] b, input int m);
    return {13'h0000, (m == 1) && (b[7] != ^b[6:0]), (m == 2) && b[7], 1'b0};
  endfunction
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic poll(input logic [15:0] m);
    for (int i = 0; i < 300; i++)
    begin
      rd(`ASP_ADDR_RXST, v);
      if ((v & m) === m)
        break;
    end
    chk(v & m, m);
    if ((v & m) !== m)
      print_verdict();
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    seed       = 32'h4c57fc30;
    bad_count  = 0;
    num_checks = 0;
    reset_n    = 1'b0;
    addr       = 16'h0000;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    wdata      = 16'h0000;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(`ASP_ADDR_CTL1, v);
    chk(v, 16'h0000);
    wr(`ASP_ADDR_CCR, 16'hFF07);
    rd(`ASP_ADDR_CCR, v);
    chk(v, 16'h0007);
    rd(16'h7058, v);
    chk(v, 16'h0000);
    wr(`ASP_ADDR_CTL1, 16'h0023);
    rd(`ASP_ADDR_CTL2, v);
    chk(v, 16'h00C0);
    wr(`ASP_ADDR_CTL2, 16'h0001);
    #1 chk({14'h0000, tx_irq, rx_irq}, 16'h0002);
    $display("registers done");
    for (int d = 0; d < 9; d += 3)
    begin
      wr(`ASP_ADDR_LBAUD, d[15:0]);
      wr(`ASP_ADDR_CCR, ccr_of(d / 3));
      peer.bt = bt_of(d);
      tb_b = 8'($random(seed));
      r = 8'($random(seed));
      fork
        wr(`ASP_ADDR_TXBUF, {8'h00, tb_b});
        peer.get(g, ok);
        peer.send(r);
      join
      chk({7'h00, ok, g}, {8'h01, on_wire(tb_b, d / 3)});
      poll(16'h0040);
      chk(v & 16'h0006, st_of(r, d / 3));
      rd(`ASP_ADDR_RXBUF, v);
      chk(v, {8'h00, r & ((d == 0) ? 8'hFF : 8'h7F)});
      $display("divisor %0d done", d);
    end
    for (int i = 0; i < 3; i++)
      peer.send(8'($random(seed)));
    poll(16'h00C8);
    wr(`ASP_ADDR_CTL1, 16'h0003);
    wr(`ASP_ADDR_CTL1, 16'h0023);
    rd(`ASP_ADDR_RXST, v);
    chk(v, 16'h0000);
    $display("overrun done");
    wr(`ASP_ADDR_CTL2, 16'h0002);
    peer.brk();
    poll(16'h00A0);
    #1 chk({14'h0000, tx_irq, rx_irq}, 16'h0001);
    $display("break done");
    wr(`ASP_ADDR_FFTX, 16'h4000);
    for (int i = 0; i < 5; i++)
      q[i] = 8'($random(seed));
    fork
      begin
        for (int i = 0; i < 5; i++)
          wr(`ASP_ADDR_TXBUF, {8'h00, q[i]});
        rd(`ASP_ADDR_FFTX, v);
        chk(v, 16'h4400);
        rd(`ASP_ADDR_CTL2, v);
        chk(v, 16'h0002);
      end
      for (int i = 0; i < 5; i++)
      begin
        peer.get(g, ok);
        chk({7'h00, ok, g}, {8'h01, on_wire(q[i], 2)});
      end
    join
    $display("queue done");
    wr(`ASP_ADDR_FFCT, 16'h2000);
    peer.bt = bt_of(5);
    peer.send(8'h55);
    rd(`ASP_ADDR_LBAUD, v);
    chk(v, 16'h0005);
    rd(`ASP_ADDR_FFCT, v);
    chk(v, 16'hA000);
    $display("rate detect done");
    print_verdict();
  end
endmodule
`default_nettype wire
